// *** hw/tfm_pkg.sv ***
// ****************************************************************
// Shared constants for the twin multiply-accumulate block
// ****************************************************************
package tfm_pkg;
  // Internal working format: sign, 8-bit exponent, 15-bit fraction
  localparam int FP24_W = 24;
  localparam int FP24_MAN_W = 15;
  localparam logic [7:0] FP24_EXP_MAX = 8'hff;
  localparam logic [9:0] FP24_BIAS = 10'h07f;
  localparam logic [23:0] FP24_QNAN = 24'h7fc000;
  // Short formats: 5-bit exponent variant rebias and limits
  localparam logic [7:0] FP16_REBIAS = 8'h70;
  localparam logic [7:0] FP16_EXP_TOP = 8'h8f;
  localparam logic [4:0] FP16_EXP_MAX = 5'h1f;
  // Error flag positions within the two-bit status
  localparam int ST_OVF = 0;
  localparam int ST_NAN = 1;
  // Word carried down the product pipeline: load, flags, value
  localparam int PW = FP24_W + 3;
  localparam int PW_LD = PW - 1;
  // Structure limits
  localparam int MAX_PIPE = 4;
  localparam int LANES = 2;
  localparam int OPERANDS = 4;
  localparam int NORMAL_IN_BITS = 72;
endpackage : tfm_pkg

// *** hw/tfm_fp24_add.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Working-format adder, combinational, flush-to-zero, truncating
// ****************************************************************
module tfm_fp24_add
  import tfm_pkg::*;
(
  // Operands
  input wire logic [23:0] a,
  input wire logic [23:0] b,
  // Result and flags
  output logic [23:0] y,
  output logic nan,
  output logic ovf
);
  logic a_big;
  logic [23:0] x;
  logic [23:0] z;
  logic [15:0] mx;
  logic [15:0] mz;
  logic [7:0] d;
  logic [18:0] al;
  logic [19:0] s;
  logic [19:0] sh;
  logic [4:0] lz;
  logic found;
  logic [8:0] en;
  logic x_inf;
  logic z_inf;
  logic x_nan;
  logic z_nan;

  // Larger magnitude first so the difference never goes negative
  assign a_big = a[22:0] >= b[22:0];
  assign x = a_big ? a : b;
  assign z = a_big ? b : a;
  assign mx = (x[22:15] != 8'h00) ? {1'b1, x[14:0]} : 16'h0000;
  assign mz = (z[22:15] != 8'h00) ? {1'b1, z[14:0]} : 16'h0000;
  assign d = x[22:15] - z[22:15];
  assign al = {mz, 3'h0} >> d;
  assign s = (x[23] ^ z[23]) ? {1'b0, mx, 3'h0} - {1'b0, al}
                             : {1'b0, mx, 3'h0} + {1'b0, al};
  assign x_inf = (x[22:15] == FP24_EXP_MAX) && (x[14:0] == 15'h0000);
  assign z_inf = (z[22:15] == FP24_EXP_MAX) && (z[14:0] == 15'h0000);
  assign x_nan = (x[22:15] == FP24_EXP_MAX) && (x[14:0] != 15'h0000);
  assign z_nan = (z[22:15] == FP24_EXP_MAX) && (z[14:0] != 15'h0000);

  // Leading-zero count below the carry bit
  always_comb begin
    lz = 5'h00;
    found = 1'b0;
    for (int i = 18; i >= 0; i--) begin
      if (!found) begin
        if (s[i]) found = 1'b1;
        else lz = lz + 5'h01;
      end
    end
  end

  assign sh = s << lz;
  assign en = {1'b0, x[22:15]} - {4'h0, lz};

  // Specials first, then carry, then normalised or flushed result
  always_comb begin
    y = 24'h000000;
    nan = 1'b0;
    ovf = 1'b0;
    if (x_nan || z_nan || (x_inf && z_inf && (x[23] ^ z[23]))) begin
      y = FP24_QNAN;
      nan = 1'b1;
    end else if (x_inf) begin
      y = x;
    end else if (s[19]) begin
      if (x[22:15] == 8'hfe) begin
        y = {x[23], FP24_EXP_MAX, 15'h0000};
        ovf = 1'b1;
      end else begin
        y = {x[23], x[22:15] + 8'h01, s[18:4]};
      end
    end else if (s != 20'h00000 && {3'h0, lz} < x[22:15]) begin
      y = {x[23], en[7:0], sh[17:3]};
    end
  end
endmodule : tfm_fp24_add

// *** hw/tfm_twin_mult.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Twin floating-point multiplier with optional accumulators
// ****************************************************************
// How it works
// - Two lanes multiply A*B and C*D side by side, each may accumulate
// - Number width is 16 or 24; 16 may use 5 or 8 exponent bits
// - Exponent width 5 or 8 picks the short format's exponent field
// - Without accumulation each output shows only its own product
// - With accumulation outputs hold running sums; user restarts them
// - Optional input registers capture operands, adding one cycle
// - Zero to four pipeline stages; latency is stages plus input stage
// - Each operand's capture enable works only when input stage exists
// - Input stage reset is synchronous, active low, only if present
// - Pipeline enable gates pipeline and accumulators unless no stages
// - Pipeline reset clears pipeline and accumulators unless no stages
// - First restart loads AB accumulator with its product when summing
// - Second restart loads CD accumulator with its product when summing
// - Restarts travel with their product through the same stages
// - Each result has a two-bit error status
// - Products and sums are formed in the 24-bit working format
// - One clock runs every register in the block
// - 24-bit numbers need 96 input bits, so the wide input mode is used
// - 16-bit numbers need 64 input bits, so normal input mode is used
module tfm_twin_mult
  import tfm_pkg::*;
#(
  parameter int number_width = 16,
  parameter int exponent_width = 5,
  parameter int accumulate = 0,
  parameter int in_reg_enable = 0,
  parameter int pipeline_regs = 0
) (
  // Clock and power-on reset
  input wire logic mclk,
  input wire logic resetn,
  // Operands
  input wire logic [number_width-1:0] operand_a,
  input wire logic [number_width-1:0] operand_b,
  input wire logic [number_width-1:0] operand_c,
  input wire logic [number_width-1:0] operand_d,
  // Input stage control
  input wire logic capture_a_en,
  input wire logic capture_b_en,
  input wire logic capture_c_en,
  input wire logic capture_d_en,
  input wire logic capture_reset_n,
  // Pipeline and accumulator control
  input wire logic pipe_en,
  input wire logic pipe_reset_n,
  input wire logic first_sum_restart,
  input wire logic second_sum_restart,
  // Results
  output logic [number_width-1:0] first_result_out,
  output logic [number_width-1:0] second_result_out,
  output logic [1:0] first_error_flags,
  output logic [1:0] second_error_flags,
  // Multiplier input mode in use
  output logic wide_input_mode
);
  localparam int PIPE_IDX = (pipeline_regs == 0) ? 0 : pipeline_regs - 1;

  // ****************************************************************
  // Format conversion and multiplication
  // ****************************************************************

  // Short formats widen exactly; subnormal inputs flush to zero
  function automatic logic [23:0] widen(
    input logic [number_width-1:0] v
  );
    logic [23:0] xp;
    logic [4:0] e5;
    logic [23:0] r;
    xp = 24'(v);
    e5 = xp[14:10];
    r = 24'h000000;
    if (number_width == 24) begin
      r = xp;
    end else if (exponent_width == 8) begin
      r = {xp[15:0], 8'h00};
    end else if (e5 == 5'h00) begin
      r = {xp[15], 23'h000000};
    end else if (e5 == FP16_EXP_MAX) begin
      r = {xp[15], FP24_EXP_MAX, xp[9:0], 5'h00};
    end else begin
      r = {xp[15], 8'(e5) + FP16_REBIAS, xp[9:0], 5'h00};
    end
    return r;
  endfunction : widen

  // Narrowing truncates; returns {nan, ovf, value padded to 24}
  function automatic logic [25:0] narrow(input logic [23:0] y);
    logic [7:0] e;
    logic nanv;
    logic [25:0] r;
    e = y[22:15];
    nanv = (e == FP24_EXP_MAX) && (y[14:0] != 15'h0000);
    r = {2'h0, y};
    if (number_width == 24) begin
      r = {2'h0, y};
    end else if (exponent_width == 8) begin
      r = {2'h0, 8'h00, y[23:9], y[8] | nanv};
    end else if (e == FP24_EXP_MAX) begin
      r = {2'h0, 8'h00, y[23], FP16_EXP_MAX, y[14:6], y[5] | nanv};
    end else if (e <= FP16_REBIAS) begin
      r = {2'h0, 8'h00, y[23], 15'h0000};
    end else if (e >= FP16_EXP_TOP) begin
      r = {2'h1, 8'h00, y[23], FP16_EXP_MAX, 10'h000};
    end else begin
      r = {2'h0, 8'h00, y[23], 5'(e - FP16_REBIAS), y[14:5]};
    end
    return r;
  endfunction : narrow

  // Working-format product; returns {nan, ovf, value}
  function automatic logic [25:0] mul24(
    input logic [23:0] a,
    input logic [23:0] b
  );
    logic sgn;
    logic ia;
    logic ib;
    logic za;
    logic zb;
    logic na;
    logic nb;
    logic [31:0] p;
    logic [9:0] e;
    logic [25:0] r;
    sgn = a[23] ^ b[23];
    ia = (a[22:15] == FP24_EXP_MAX) && (a[14:0] == 15'h0000);
    ib = (b[22:15] == FP24_EXP_MAX) && (b[14:0] == 15'h0000);
    na = (a[22:15] == FP24_EXP_MAX) && !ia;
    nb = (b[22:15] == FP24_EXP_MAX) && !ib;
    za = a[22:15] == 8'h00;
    zb = b[22:15] == 8'h00;
    p = {1'b1, a[14:0]} * {1'b1, b[14:0]};
    e = {2'h0, a[22:15]} + {2'h0, b[22:15]} - FP24_BIAS + 10'(p[31]);
    r = {2'h0, sgn, 23'h000000};
    if (na || nb || (ia && zb) || (ib && za)) begin
      r = {2'h2, FP24_QNAN};
    end else if (ia || ib) begin
      r = {2'h0, sgn, FP24_EXP_MAX, 15'h0000};
    end else if (za || zb || e[9] || e == 10'h000) begin
      r = {2'h0, sgn, 23'h000000};
    end else if (e >= 10'h0ff) begin
      r = {2'h1, sgn, FP24_EXP_MAX, 15'h0000};
    end else if (p[31]) begin
      r = {2'h0, sgn, e[7:0], p[30:16]};
    end else begin
      r = {2'h0, sgn, e[7:0], p[29:15]};
    end
    return r;
  endfunction : mul24

  // ****************************************************************
  // Input stage
  // ****************************************************************

  logic [number_width-1:0] op_in [OPERANDS];
  logic [number_width-1:0] op_use [OPERANDS];
  logic [OPERANDS-1:0] cap_en;
  logic [LANES-1:0] ld_in;
  logic [LANES-1:0] ld_use;

  assign op_in[0] = operand_a;
  assign op_in[1] = operand_b;
  assign op_in[2] = operand_c;
  assign op_in[3] = operand_d;
  assign cap_en = {capture_d_en, capture_c_en, capture_b_en, capture_a_en};
  assign ld_in = {second_sum_restart, first_sum_restart};

  // Four operands need more than the normal path for 24-bit numbers
  assign wide_input_mode =
    (number_width * OPERANDS) > NORMAL_IN_BITS;

  if (in_reg_enable == 1) begin : g_capture
    logic [number_width-1:0] op_q [OPERANDS];
    logic [LANES-1:0] ld_q;

    // Per-operand enables; restarts ride along so they stay aligned
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        op_q <= '{default: '0};
        ld_q <= '0;
      end else if (!capture_reset_n) begin
        op_q <= '{default: '0};
        ld_q <= '0;
      end else begin
        for (int i = 0; i < OPERANDS; i++) begin
          if (cap_en[i]) op_q[i] <= op_in[i];
        end
        ld_q <= ld_in;
      end
    end
    assign op_use = op_q;
    assign ld_use = ld_q;

    a_capture_hold: assert property (
      @(posedge mclk) disable iff (!resetn)
      capture_reset_n && !capture_a_en |=> $stable(op_q[0]))
      else $error("operand A register moved without its enable");
    a_capture_clear: assert property (
      @(posedge mclk) disable iff (!resetn)
      !capture_reset_n |=> op_q[1] == '0 && ld_q == '0)
      else $error("input stage reset did not clear operand B");
    a_capture_take: assert property (
      @(posedge mclk) disable iff (!resetn)
      capture_reset_n && capture_c_en |=> op_q[2] == $past(operand_c))
      else $error("operand C not captured on its enable");
  end else begin : g_direct
    // Enables and input reset have nothing to act on here
    assign op_use = op_in;
    assign ld_use = ld_in;
  end

  // ****************************************************************
  // Product lanes: multiply, pipeline, accumulate, narrow
  // ****************************************************************

  logic acc_en;
  logic acc_clr;
  logic [25:0] res [LANES];

  // With no stages the pipeline controls are ignored
  assign acc_en = (pipeline_regs == 0) || pipe_en;
  assign acc_clr = (pipeline_regs != 0) && !pipe_reset_n;

  for (genvar g = 0; g < LANES; g++) begin : lane
    logic [25:0] prod;
    logic [PW-1:0] head;
    logic [PW-1:0] tail;
    logic [PW-1:0] stg [MAX_PIPE];
    logic [23:0] tail_prod;
    logic tail_ld;
    logic [23:0] sum_word;
    logic sum_nan;
    logic sum_ovf;
    logic [23:0] acc_q;
    logic [1:0] acc_flags;
    logic [23:0] next_acc;
    logic [1:0] next_flags;
    logic [23:0] res_word;
    logic [1:0] res_flags;

    // Both operands widened, product formed in the working format
    assign prod = mul24(widen(op_use[2*g]),
                        widen(op_use[2*g+1]));
    assign head = {ld_use[g], prod};

    // Delay line shared by product, flags and restart
    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        stg <= '{default: '0};
      end else if (acc_clr) begin
        stg <= '{default: '0};
      end else if (pipe_en) begin
        stg[0] <= head;
        for (int k = 1; k < MAX_PIPE; k++) stg[k] <= stg[k-1];
      end
    end

    // Tap after the configured number of stages
    assign tail = (pipeline_regs == 0) ? head : stg[PIPE_IDX];
    assign tail_prod = tail[23:0];
    assign tail_ld = tail[PW_LD];

    tfm_fp24_add u_add (
      .a(acc_q),
      .b(tail_prod),
      .y(sum_word),
      .nan(sum_nan),
      .ovf(sum_ovf)
    );

    // Restart discards the old sum; flags stay sticky within a sum
    assign next_acc = tail_ld ? tail_prod : sum_word;
    assign next_flags = tail_ld ? tail[25:24]
                      : acc_flags | tail[25:24] | {sum_nan, sum_ovf};

    always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
        acc_q <= 24'h000000;
        acc_flags <= 2'h0;
      end else if (accumulate == 1 && acc_clr) begin
        acc_q <= 24'h000000;
        acc_flags <= 2'h0;
      end else if (accumulate == 1 && acc_en) begin
        acc_q <= next_acc;
        acc_flags <= next_flags;
      end
    end

    // Direct product unless accumulating; restart ignored then
    assign res_word = (accumulate == 1) ? next_acc : tail_prod;
    assign res_flags = (accumulate == 1) ? next_flags : tail[25:24];
    assign res[g] = narrow(res_word) | {res_flags, 24'h000000};
  end

  // Flags combine arithmetic and narrowing errors
  assign first_result_out = res[0][number_width-1:0];
  assign second_result_out = res[1][number_width-1:0];
  assign first_error_flags = res[0][25:24];
  assign second_error_flags = res[1][25:24];

  // ****************************************************************
  // Checks
  // ****************************************************************

  a_pipe_stall: assert property (
    @(posedge mclk) disable iff (!resetn)
    pipeline_regs > 0 && pipe_reset_n && !pipe_en
    |=> $stable(lane[0].stg[0]) && $stable(lane[1].stg[MAX_PIPE-1]))
    else $error("pipeline moved while its enable was low");

  a_pipe_clear: assert property (
    @(posedge mclk) disable iff (!resetn)
    pipeline_regs > 0 && !pipe_reset_n
    |=> lane[1].acc_q == 24'h000000 && lane[0].stg[0] == '0)
    else $error("pipeline reset did not clear stages and sums");

  a_first_restart: assert property (
    @(posedge mclk) disable iff (!resetn)
    accumulate == 1 && lane[0].tail_ld && acc_en && !acc_clr
    |=> lane[0].acc_q == $past(lane[0].tail_prod))
    else $error("first restart did not load the AB product");

  a_second_restart: assert property (
    @(posedge mclk) disable iff (!resetn)
    accumulate == 1 && lane[1].tail_ld && acc_en && !acc_clr
    |=> lane[1].acc_q == $past(lane[1].tail_prod))
    else $error("second restart did not load the CD product");

  a_running_sum: assert property (
    @(posedge mclk) disable iff (!resetn)
    accumulate == 1 && !lane[0].tail_ld && acc_en && !acc_clr
    |=> lane[0].acc_q == $past(lane[0].sum_word))
    else $error("AB accumulator did not add its product");

  a_direct_product: assert property (
    @(posedge mclk) disable iff (!resetn)
    accumulate == 0
    |-> first_result_out == number_width'(narrow(lane[0].tail_prod))
        && second_error_flags[ST_NAN] == lane[1].tail[25])
    else $error("direct mode result is not the product");

  a_strobe_delay: assert property (
    @(posedge mclk) disable iff (!resetn)
    pipeline_regs > 0 && pipe_reset_n && pipe_en
    |=> lane[1].stg[0][PW_LD] == $past(ld_use[1])
        && lane[1].stg[0][23:0] == $past(lane[1].prod[23:0]))
    else $error("restart strobe left its product behind");

  a_input_mode: assert property (
    @(posedge mclk) disable iff (!resetn)
    wide_input_mode == (number_width == 24))
    else $error("input mode does not match number width");

endmodule : tfm_twin_mult

// *** verif/tfm_user_model.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Fabric-side operand source for the twin multiplier
// ****************************************************************
module tfm_user_model
  import tfm_pkg::*;
#(
  parameter int number_width = 16
) (
  // Clock
  input wire logic mclk,
  // Operands and restart strobes toward the block
  output logic [number_width-1:0] operand_a,
  output logic [number_width-1:0] operand_b,
  output logic [number_width-1:0] operand_c,
  output logic [number_width-1:0] operand_d,
  output logic first_sum_restart,
  output logic second_sum_restart
);
  // Operands start at zero; between calls they keep the last set put
  initial begin
    operand_a = '0;
    operand_b = '0;
    operand_c = '0;
    operand_d = '0;
    first_sum_restart = 1'b0;
    second_sum_restart = 1'b0;
  end

  // One operand set per call, launched just after a rising edge
  task automatic put(input logic [number_width-1:0] a,
                     input logic [number_width-1:0] b,
                     input logic [number_width-1:0] c,
                     input logic [number_width-1:0] d,
                     input logic r1, input logic r2);
    @(posedge mclk);
    operand_a <= a;
    operand_b <= b;
    operand_c <= c;
    operand_d <= d;
    first_sum_restart <= r1;
    second_sum_restart <= r2;
  endtask : put
endmodule : tfm_user_model

// *** verif/tfm_twin_mult_tb.sv ***
`timescale 1ns/1ps
// ****************************************************************
// Bench: fp16 e5, accumulating, input stage plus one pipe stage; beside it a direct fp16 e8 copy
// ****************************************************************
module tfm_twin_mult_tb;
  import tfm_pkg::*;
  logic mclk, resetn;
  logic [15:0] operand_a, operand_b, operand_c, operand_d;
  logic capture_a_en, capture_b_en, capture_c_en, capture_d_en;
  logic capture_reset_n, pipe_en, pipe_reset_n;
  logic first_sum_restart, second_sum_restart;
  logic [15:0] first_result_out, second_result_out;
  logic [1:0] first_error_flags, second_error_flags;
  logic wide_input_mode;
  logic [15:0] direct_first_result, direct_second_result;
  logic [1:0] direct_first_flags, direct_second_flags;
  int mismatches = 0;
  int checks_done = 0;

  tfm_user_model u_tfm_user_model (
    .mclk(mclk), .operand_a(operand_a), .operand_b(operand_b),
    .operand_c(operand_c), .operand_d(operand_d),
    .first_sum_restart(first_sum_restart),
    .second_sum_restart(second_sum_restart));

  // Latency is two: one input stage and one pipeline stage
  tfm_twin_mult #(.accumulate(1), .in_reg_enable(1), .pipeline_regs(1))
    u_tfm_twin_mult (
    .mclk(mclk), .resetn(resetn), .operand_a(operand_a),
    .operand_b(operand_b), .operand_c(operand_c), .operand_d(operand_d),
    .capture_a_en(capture_a_en), .capture_b_en(capture_b_en),
    .capture_c_en(capture_c_en), .capture_d_en(capture_d_en),
    .capture_reset_n(capture_reset_n), .pipe_en(pipe_en),
    .pipe_reset_n(pipe_reset_n), .first_sum_restart(first_sum_restart),
    .second_sum_restart(second_sum_restart),
    .first_result_out(first_result_out),
    .second_result_out(second_result_out),
    .first_error_flags(first_error_flags),
    .second_error_flags(second_error_flags),
    .wide_input_mode(wide_input_mode));

  // Latency zero, no sums, short format with an 8-bit exponent
  tfm_twin_mult #(.exponent_width(8)) u_tfm_twin_mult_direct (
    .mclk(mclk), .resetn(resetn), .operand_a(operand_a),
    .operand_b(operand_b), .operand_c(operand_c), .operand_d(operand_d),
    .capture_a_en(capture_a_en), .capture_b_en(capture_b_en),
    .capture_c_en(capture_c_en), .capture_d_en(capture_d_en),
    .capture_reset_n(capture_reset_n), .pipe_en(pipe_en),
    .pipe_reset_n(pipe_reset_n), .first_sum_restart(first_sum_restart),
    .second_sum_restart(second_sum_restart),
    .first_result_out(direct_first_result),
    .second_result_out(direct_second_result),
    .first_error_flags(direct_first_flags),
    .second_error_flags(direct_second_flags),
    .wide_input_mode());

  // ****************************************************************
  // Clock, verdict and comparison helpers
  // ****************************************************************
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // Both lanes compared together, one line per call site
  task automatic check2(input string name, input logic [15:0] e1,
                        input logic [15:0] e2);
    check({name, " first"}, first_result_out, e1);
    check({name, " second"}, second_result_out, e2);
  endtask : check2

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Three back-to-back operand sets, restart on the first only
  task automatic run_stream(input string name,
                            input logic [15:0] op [0:11],
                            input logic [15:0] ex [0:5]);
    for (int i = 0; i < 3; i++) begin
      u_tfm_user_model.put(op[4*i], op[4*i+1], op[4*i+2], op[4*i+3],
                           i == 0, i == 0);
    end
    for (int i = 0; i < 3; i++) begin
      if (i > 0) @(posedge mclk);
      #1;
      check2(name, ex[2*i], ex[2*i+1]);
    end
  endtask : run_stream

  // Disabled capture keeps the old operand while its input moves to 4400
  task automatic t_capture_en();
    u_tfm_user_model.put(16'h4000, 16'h4000, 16'h4000, 16'h4000, 1, 1);
    u_tfm_user_model.put(16'h4400, 16'h4400, 16'h4000, 16'h4400, 1, 1);
    capture_a_en <= 1'b0;
    capture_b_en <= 1'b0;
    capture_d_en <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check2("capture hold", 16'h4400, 16'h4400);
    @(posedge mclk);
    capture_a_en <= 1'b1;
    capture_b_en <= 1'b1;
    capture_d_en <= 1'b1;
  endtask : t_capture_en

  // Input stage reset zeroes a and c, which then stay held at zero
  task automatic t_capture_reset();
    u_tfm_user_model.put(16'h4000, 16'h4200, 16'h4000, 16'h4200, 1, 1);
    capture_a_en <= 1'b0;
    capture_c_en <= 1'b0;
    capture_reset_n <= 1'b0;
    @(posedge mclk);
    capture_reset_n <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check2("capture reset", 16'h0000, 16'h0000);
    @(posedge mclk);
    capture_a_en <= 1'b1;
    capture_c_en <= 1'b1;
  endtask : t_capture_reset

  // Pipeline enable low freezes the restart product and the sum
  task automatic t_pipe_hold();
    u_tfm_user_model.put(16'h4000, 16'h4000, 16'h4000, 16'h4000, 1, 1);
    u_tfm_user_model.put(16'h4000, 16'h4000, 16'h4000, 16'h4000, 0, 0);
    @(posedge mclk);
    pipe_en <= 1'b0;
    #1;
    check2("pipe before hold", 16'h4400, 16'h4400);
    repeat (3) @(posedge mclk);
    #1;
    check2("pipe hold", 16'h4400, 16'h4400);
    @(posedge mclk);
    pipe_en <= 1'b1;
    @(posedge mclk);
    #1;
    check2("pipe resume", 16'h4800, 16'h4800);
  endtask : t_pipe_hold

  // Pipeline reset clears the stage and the accumulator together
  task automatic t_pipe_reset();
    u_tfm_user_model.put(16'h3c00, 16'h3c00, 16'h3c00, 16'h3c00, 0, 0);
    @(posedge mclk);
    pipe_reset_n <= 1'b0;
    @(posedge mclk);
    pipe_reset_n <= 1'b1;
    #1;
    check2("pipe cleared", 16'h0000, 16'h0000);
    @(posedge mclk);
    #1;
    check2("sum after clear", 16'h3c00, 16'h3c00);
  endtask : t_pipe_reset

  // Overflow on the first lane, infinity times zero on the second
  task automatic t_error_flags();
    u_tfm_user_model.put(16'h7bff, 16'h7bff, 16'h7c00, 16'h0000, 1, 1);
    repeat (2) @(posedge mclk);
    #1;
    check("first flags", {14'h0000, first_error_flags}, 16'h0001);
    check("second flags", {14'h0000, second_error_flags}, 16'h0002);
  endtask : t_error_flags

  // Without stages every control and restart must be ignored
  task automatic t_direct();
    u_tfm_user_model.put(16'h4000, 16'h4040, 16'h4040, 16'h4040, 1, 1);
    capture_a_en <= 1'b0;
    capture_reset_n <= 1'b0;
    pipe_en <= 1'b0;
    pipe_reset_n <= 1'b0;
    #1;
    check("direct first", direct_first_result, 16'h40c0);
    check("direct second", direct_second_result, 16'h4110);
    check("direct flags", {12'h000, direct_first_flags, direct_second_flags},
          16'h0000);
    @(posedge mclk);
    #1;
    check("direct held first", direct_first_result, 16'h40c0);
    check("direct held second", direct_second_result, 16'h4110);
    check("direct no restart", direct_first_result, 16'h40c0);
  endtask : t_direct

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    resetn = 1'b0;
    capture_a_en = 1'b1;
    capture_b_en = 1'b1;
    capture_c_en = 1'b1;
    capture_d_en = 1'b1;
    capture_reset_n = 1'b1;
    pipe_en = 1'b1;
    pipe_reset_n = 1'b1;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    #1;
    check("wide mode", {15'h0000, wide_input_mode}, 16'h0000);
    // Sums 3,7,8 and 6,6.5,7: restart lines up with its product
    run_stream("accumulate", '{16'h3e00, 16'h4000, 16'h4200, 16'h4000,
      16'h4000, 16'h4000, 16'h3800, 16'h3c00, 16'h3c00, 16'h3c00,
      16'h3800, 16'h3c00}, '{16'h4200, 16'h4600, 16'h4700, 16'h4680,
      16'h4800, 16'h4700});
    // 1024 + 0.5 + 0.5 only reaches 1025 if the sum is kept wider
    run_stream("working format", '{16'h5000, 16'h5000, 16'h3c00, 16'h3c00,
      16'h3800, 16'h3c00, 16'h3c00, 16'h3c00, 16'h3800, 16'h3c00,
      16'h3c00, 16'h3c00}, '{16'h6400, 16'h3c00, 16'h6400, 16'h4000,
      16'h6401, 16'h4200});
    t_capture_en();
    t_capture_reset();
    t_pipe_hold();
    t_pipe_reset();
    t_error_flags();
    t_direct();
    finish_test();
  end

  // Whole run is well under two hundred cycles
  initial begin
    repeat (2000) @(posedge mclk);
    mismatches++;
    finish_test();
  end
endmodule : tfm_twin_mult_tb
